// file: verilog/iob_pkg.sv
// constants shared by the index offset, status and byte enable block
package iob_pkg;

	// ***************************************************************
	// register byte addresses
	// ***************************************************************
	localparam logic [7:0] IOB_ADDR_VECTOR = 8'h00;
	localparam logic [7:0] IOB_ADDR_SIZE = 8'h04;
	localparam logic [7:0] IOB_ADDR_C_FLAGS = 8'h08;
	localparam logic [7:0] IOB_ADDR_INDEX_A = 8'h0C;
	localparam logic [7:0] IOB_ADDR_INDEX_B = 8'h10;
	localparam logic [7:0] IOB_ADDR_INDEX_C = 8'h14;
	localparam logic [7:0] IOB_ADDR_WRITE_OUT = 8'h18;
	localparam logic [7:0] IOB_ADDR_STATUS = 8'h1C;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int IOB_VEC_BUS_LSB = 0;
	localparam int IOB_VEC_STA_LSB = 2;
	localparam int IOB_VEC_STWE_ON = 5;
	localparam int IOB_VEC_STWE_INV = 6;
	localparam int IOB_VEC_WCTL_DLY = 7;
	localparam int IOB_VEC_OFFA_LSB = 8;
	localparam int IOB_VEC_OFFB_LSB = 12;
	localparam int IOB_VEC_OFFC_LSB = 16;
	localparam int IOB_VEC_BASEA_LSB = 20;
	localparam int IOB_VEC_BASEB_LSB = 22;
	localparam int IOB_VEC_BASEC_LSB = 24;
	localparam int IOB_SIZE_A_LSB = 0;
	localparam int IOB_SIZE_B_LSB = 4;
	localparam int IOB_SIZE_C_LSB = 8;
	localparam int IOB_SIZE_XWE_LSB = 12;
	localparam int IOB_SIZE_XWE_ON = 16;
	localparam int IOB_CF_PRE_LSB = 0;
	localparam int IOB_CF_RES_LSB = 8;
	localparam int IOB_CF_DLY_LSB = 16;
	localparam int IOB_MODE_DELAYED = 3;

	// ***************************************************************
	// reset values and writable masks
	// ***************************************************************
	localparam logic [31:0] IOB_VECTOR_RST = 32'h0000_0000;
	localparam logic [31:0] IOB_SIZE_RST = 32'h0000_F777;
	localparam logic [31:0] IOB_C_FLAGS_RST = 32'h0000_0000;
	localparam logic [31:0] IOB_VECTOR_MASK = 32'h03FF_FFFF;
	localparam logic [31:0] IOB_SIZE_MASK = 32'h0001_F777;
	localparam logic [31:0] IOB_C_FLAGS_MASK = 32'h0000_FFFF;

	// ***************************************************************
	// encodings
	// ***************************************************************
	localparam logic [1:0] IOB_BUS_B = 2'h0;
	localparam logic [1:0] IOB_BUS_M = 2'h1;
	localparam logic [1:0] IOB_BUS_A = 2'h2;
	localparam logic [1:0] IOB_BUS_V = 2'h3;
	localparam logic [1:0] IOB_DSIZE_4X8 = 2'h0;
	localparam logic [1:0] IOB_DSIZE_2X16 = 2'h1;
	localparam logic [1:0] IOB_DSIZE_1X32 = 2'h2;
	localparam logic [1:0] IOB_BASE_ZERO = 2'h0;
	localparam logic [1:0] IOB_BASE_CURRENT = 2'h2;
	localparam logic [1:0] IOB_BASE_READ_A = 2'h3;
	localparam logic [1:0] IOB_PR_NEVER = 2'h0;
	localparam logic [1:0] IOB_PR_IF_TRUE = 2'h1;
	localparam logic [1:0] IOB_PR_IF_FALSE = 2'h2;
	localparam logic [1:0] IOB_PR_ALWAYS = 2'h3;
	localparam logic [1:0] IOB_RESP_OKAY = 2'h0;
	localparam logic [1:0] IOB_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		IOB_ST_ZERO, IOB_ST_MINUS, IOB_ST_CARRY, IOB_ST_SIGNED_COMPARE,
		IOB_ST_INSIDE, IOB_ST_HIGHER, IOB_ST_LOWER, IOB_ST_WRONG
	} iob_status_e;

endpackage

// file: verilog/iob_index_lane.sv
// one byte lane of a vector index generator
module iob_index_lane (
	// control
	input wire logic [1:0] base_sel,
	input wire logic [3:0] mode,
	input wire logic [2:0] isize,
	// data
	input wire logic [7:0] cur_index,
	input wire logic [7:0] read_a_index,
	input wire logic [7:0] offset,
	input wire logic status_now,
	input wire logic status_old,
	// result
	output logic [7:0] next_index
);
	import iob_pkg::*;

	logic [7:0] base;
	logic [7:0] incr;
	logic [7:0] sum;
	logic [7:0] mask;
	logic st;

	always_comb begin
		// bit 3 of the mode picks the saved flag
		st = mode[IOB_MODE_DELAYED] ? status_old : status_now;
		if (base_sel == IOB_BASE_CURRENT) begin
			base = cur_index;
		end else if (base_sel == IOB_BASE_READ_A) begin
			base = read_a_index;
		end else begin
			base = 8'h00;
		end
		case (mode[2:0])
			3'h0: incr = 8'h00;
			3'h1: incr = 8'h01;
			3'h2: incr = offset;
			3'h3: incr = offset + 8'h01;
			3'h4: incr = st ? 8'h01 : 8'h00;
			3'h5: incr = st ? 8'h00 : 8'h01;
			3'h6: incr = st ? offset : 8'h00;
			default: incr = st ? 8'h00 : offset;
		endcase
		sum = base + incr;
		// bits above the size stay as they were
		mask = 8'hFF >> (3'h7 - isize);
		next_index = (sum & mask) | (cur_index & ~mask);
	end
endmodule

// file: verilog/iob_byte_flags.sv
// preset and reset flag of one byte of write port c
module iob_byte_flags (
	// control
	input wire logic [1:0] preset_mode,
	input wire logic [1:0] reset_mode,
	input wire logic status,
	// result
	output logic preset,
	output logic reset
);
	import iob_pkg::*;

	function automatic logic decode(input logic [1:0] m, input logic s);
		case (m)
			IOB_PR_NEVER: decode = 1'b0;
			IOB_PR_IF_TRUE: decode = s;
			IOB_PR_IF_FALSE: decode = ~s;
			default: decode = 1'b1;
		endcase
	endfunction

	always_comb begin
		preset = decode(preset_mode, status);
		reset = decode(reset_mode, status);
	end
endmodule

// file: verilog/iob_top.sv
// offset, status and byte enable selection for the three register ports
module iob_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// internal buses and their data sizes
	input wire logic [31:0] a_bus,
	input wire logic [31:0] b_bus,
	input wire logic [31:0] m_bus,
	input wire logic [31:0] v_bus,
	input wire logic [1:0] a_bus_size,
	input wire logic [1:0] b_bus_size,
	input wire logic [1:0] m_bus_size,
	input wire logic [1:0] v_bus_size,
	// alu and range unit status
	input wire logic [31:0] alu_range_status_reg,
	// index generation steps
	input wire logic gen_a,
	input wire logic gen_b,
	input wire logic gen_c,
	// write port c data
	input wire logic wr_valid,
	input wire logic xi_write,
	input wire logic [31:0] wr_data,
	output logic wr_out_valid,
	output logic [31:0] wr_out_data,
	output logic [3:0] wr_out_byte_en,
	// indices
	output logic [31:0] index_a,
	output logic [31:0] index_b,
	output logic [31:0] index_c
);
	import iob_pkg::*;

	// ***************************************************************
	// control registers
	// ***************************************************************
	logic [31:0] vector_reg, next_vector_reg;
	logic [31:0] size_reg, next_size_reg;
	logic [31:0] c_flags_reg, next_c_flags_reg;
	logic [3:0] delayed_flags, next_delayed_flags;

	logic [1:0] offset_bus_select;
	iob_status_e status_select;
	logic status_write_enable_on, status_write_enable_invert;
	logic write_control_delayed_select;
	logic [3:0] port_a_offset_mode, port_b_offset_mode, port_c_offset_mode;
	logic [1:0] index_base_select [3];
	logic [2:0] index_size_field [3];
	logic [3:0] mode_of [3];
	logic [3:0] ext_write_en;
	logic ext_write_en_on;
	logic [7:0] byte_preset_mode, byte_reset_mode;

	always_comb begin
		offset_bus_select = vector_reg[IOB_VEC_BUS_LSB +: 2];
		status_select = iob_status_e'(vector_reg[IOB_VEC_STA_LSB +: 3]);
		status_write_enable_on = vector_reg[IOB_VEC_STWE_ON];
		status_write_enable_invert = vector_reg[IOB_VEC_STWE_INV];
		write_control_delayed_select = vector_reg[IOB_VEC_WCTL_DLY];
		port_a_offset_mode = vector_reg[IOB_VEC_OFFA_LSB +: 4];
		port_b_offset_mode = vector_reg[IOB_VEC_OFFB_LSB +: 4];
		port_c_offset_mode = vector_reg[IOB_VEC_OFFC_LSB +: 4];
		mode_of[0] = port_a_offset_mode;
		mode_of[1] = port_b_offset_mode;
		mode_of[2] = port_c_offset_mode;
		index_base_select[0] = vector_reg[IOB_VEC_BASEA_LSB +: 2];
		index_base_select[1] = vector_reg[IOB_VEC_BASEB_LSB +: 2];
		index_base_select[2] = vector_reg[IOB_VEC_BASEC_LSB +: 2];
		index_size_field[0] = size_reg[IOB_SIZE_A_LSB +: 3];
		index_size_field[1] = size_reg[IOB_SIZE_B_LSB +: 3];
		index_size_field[2] = size_reg[IOB_SIZE_C_LSB +: 3];
		ext_write_en = size_reg[IOB_SIZE_XWE_LSB +: 4];
		ext_write_en_on = size_reg[IOB_SIZE_XWE_ON];
		byte_preset_mode = c_flags_reg[IOB_CF_PRE_LSB +: 8];
		byte_reset_mode = c_flags_reg[IOB_CF_RES_LSB +: 8];
	end

	// ***************************************************************
	// offset and status selection
	// ***************************************************************
	logic [31:0] sel_bus;
	logic [1:0] sel_size;
	logic [7:0] offset [4];
	logic [3:0] status_now;
	logic [3:0] ctrl_status;

	always_comb begin
		if (offset_bus_select == IOB_BUS_B) begin
			sel_bus = b_bus;
			sel_size = b_bus_size;
		end else if (offset_bus_select == IOB_BUS_M) begin
			sel_bus = m_bus;
			sel_size = m_bus_size;
		end else if (offset_bus_select == IOB_BUS_A) begin
			sel_bus = a_bus;
			sel_size = a_bus_size;
		end else begin
			sel_bus = v_bus;
			sel_size = v_bus_size;
		end
		for (int y = 0; y < 4; y++) begin
			case (sel_size)
				IOB_DSIZE_4X8: offset[y] = sel_bus[8*y +: 8];
				IOB_DSIZE_2X16: offset[y] = sel_bus[16*(y/2) +: 8];
				default: offset[y] = sel_bus[7:0];
			endcase
			// flags follow the alu operation size, nothing to fix here
			status_now[y] = alu_range_status_reg[8*y + int'(status_select)];
		end
		ctrl_status = write_control_delayed_select ? delayed_flags : status_now;
	end

	// ***************************************************************
	// index generators, twelve byte lanes
	// ***************************************************************
	logic [31:0] index_q [3];
	logic [31:0] index_d [3];
	logic [31:0] next_index [3];
	logic [2:0] gen_step;

	always_comb begin
		gen_step = {gen_c, gen_b, gen_a};
		for (int p = 0; p < 3; p++) begin
			next_index[p] = gen_step[p] ? index_d[p] : index_q[p];
		end
		// a port a step saves the current flags, held until the next port a step
		next_delayed_flags = gen_a ? status_now : delayed_flags;
	end

	for (genvar p = 0; p < 3; p++) begin : g_port
		for (genvar y = 0; y < 4; y++) begin : g_byte
			iob_index_lane u_lane (
				.base_sel(index_base_select[p]),
				.mode(mode_of[p]),
				.isize(index_size_field[p]),
				.cur_index(index_q[p][8*y +: 8]),
				.read_a_index(index_q[0][8*y +: 8]),
				.offset(offset[y]),
				.status_now(status_now[y]),
				.status_old(delayed_flags[y]),
				.next_index(index_d[p][8*y +: 8])
			);
		end
	end

	// ***************************************************************
	// write enables, presets and resets for port c
	// ***************************************************************
	logic [3:0] cond_we, byte_we, byte_preset, byte_reset;
	logic [31:0] next_wr_out_data;
	logic [3:0] next_wr_out_byte_en;

	for (genvar y = 0; y < 4; y++) begin : g_flags
		iob_byte_flags u_flags (
			.preset_mode(byte_preset_mode[2*y +: 2]),
			.reset_mode(byte_reset_mode[2*y +: 2]),
			.status(ctrl_status[y]),
			.preset(byte_preset[y]),
			.reset(byte_reset[y])
		);
	end

	always_comb begin
		if (status_write_enable_on) begin
			cond_we = ctrl_status ^ {4{status_write_enable_invert}};
		end else begin
			cond_we = 4'hF;
		end
		byte_we = ext_write_en_on ? (cond_we & ext_write_en) : cond_we;
		next_wr_out_data = wr_data;
		next_wr_out_byte_en = wr_valid ? byte_we : 4'h0;
		// reset wins over preset when both are set
		for (int y = 0; y < 4; y++) begin
			if (wr_valid && xi_write && byte_reset[y]) begin
				next_wr_out_data[8*y +: 8] = 8'h00;
			end else if (wr_valid && xi_write && byte_preset[y]) begin
				next_wr_out_data[8*y +: 8] = 8'hFF;
			end
		end
	end

	// ***************************************************************
	// axi4-lite slave
	// ***************************************************************
	logic aw_full, next_aw_full, w_full, next_w_full;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, wmask;
	logic do_write;

	always_comb begin
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_vector_reg = vector_reg;
		next_size_reg = size_reg;
		next_c_flags_reg = c_flags_reg;
		wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		do_write = aw_full && w_full && !s_axi_bvalid;
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = IOB_RESP_OKAY;
			if (aw_addr == IOB_ADDR_VECTOR) begin
				next_vector_reg = (vector_reg & ~wmask) | (w_data & wmask & IOB_VECTOR_MASK);
			end else if (aw_addr == IOB_ADDR_SIZE) begin
				next_size_reg = (size_reg & ~wmask) | (w_data & wmask & IOB_SIZE_MASK);
			end else if (aw_addr == IOB_ADDR_C_FLAGS) begin
				next_c_flags_reg = (c_flags_reg & ~wmask) | (w_data & wmask & IOB_C_FLAGS_MASK);
			end else if (aw_addr == IOB_ADDR_INDEX_A || aw_addr == IOB_ADDR_INDEX_B
				|| aw_addr == IOB_ADDR_INDEX_C || aw_addr == IOB_ADDR_WRITE_OUT
				|| aw_addr == IOB_ADDR_STATUS) begin
				next_bresp = IOB_RESP_OKAY;
			end else begin
				next_bresp = IOB_RESP_SLVERR;
			end
		end
		// one write in flight; ready drops until the response is taken
		next_awready = !next_aw_full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
	end

	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = IOB_RESP_OKAY;
			if (s_axi_araddr == IOB_ADDR_VECTOR) begin
				next_rdata = vector_reg;
			end else if (s_axi_araddr == IOB_ADDR_SIZE) begin
				next_rdata = size_reg;
			end else if (s_axi_araddr == IOB_ADDR_C_FLAGS) begin
				next_rdata = c_flags_reg | {12'h000, delayed_flags, 16'h0000};
			end else if (s_axi_araddr == IOB_ADDR_INDEX_A) begin
				next_rdata = index_q[0];
			end else if (s_axi_araddr == IOB_ADDR_INDEX_B) begin
				next_rdata = index_q[1];
			end else if (s_axi_araddr == IOB_ADDR_INDEX_C) begin
				next_rdata = index_q[2];
			end else if (s_axi_araddr == IOB_ADDR_WRITE_OUT) begin
				next_rdata = {20'h00000, byte_reset, byte_preset, byte_we};
			end else if (s_axi_araddr == IOB_ADDR_STATUS) begin
				next_rdata = alu_range_status_reg;
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = IOB_RESP_SLVERR;
			end
		end
		next_arready = !next_rvalid;
	end

	// ***************************************************************
	// state registers
	// ***************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vector_reg <= IOB_VECTOR_RST;
			size_reg <= IOB_SIZE_RST;
			c_flags_reg <= IOB_C_FLAGS_RST;
			delayed_flags <= 4'h0;
			index_q <= '{default: 32'h0000_0000};
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
			wr_out_valid <= 1'b0;
			wr_out_data <= 32'h0000_0000;
			wr_out_byte_en <= 4'h0;
		end else begin
			vector_reg <= next_vector_reg;
			size_reg <= next_size_reg;
			c_flags_reg <= next_c_flags_reg;
			delayed_flags <= next_delayed_flags;
			index_q <= next_index;
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			wr_out_valid <= wr_valid;
			wr_out_data <= next_wr_out_data;
			wr_out_byte_en <= next_wr_out_byte_en;
		end
	end

	always_comb begin
		index_a = index_q[0];
		index_b = index_q[1];
		index_c = index_q[2];
	end

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_word_offset_same: assert property (
		sel_size == IOB_DSIZE_1X32 |-> offset[3] == sel_bus[7:0] && offset[1] == sel_bus[7:0])
		else $error("word offsets differ");
	a_half_offset_pair: assert property (
		sel_size == IOB_DSIZE_2X16 |-> offset[2] == sel_bus[23:16] && offset[1] == sel_bus[7:0])
		else $error("half offsets wrong");
	a_status_pick_bits: assert property (
		status_now[3] == alu_range_status_reg[24 + int'(status_select)])
		else $error("status bit pick wrong");
	a_delay_capture: assert property (
		gen_a |=> delayed_flags == $past(status_now))
		else $error("delayed flags not saved");
	a_enable_all_on: assert property (
		wr_valid && !status_write_enable_on && !ext_write_en_on |=> wr_out_byte_en == 4'hF)
		else $error("enables not all one");
	a_enable_inverted: assert property (
		wr_valid && status_write_enable_on && status_write_enable_invert && !ext_write_en_on
		|=> wr_out_byte_en == ~$past(ctrl_status))
		else $error("inverted enable wrong");
	a_ext_and_cond: assert property (
		ext_write_en_on |=> (wr_out_byte_en & ~$past(ext_write_en)) == 4'h0)
		else $error("extended enable ignored");
	a_normal_untouched: assert property (
		!xi_write |=> wr_out_data == $past(wr_data))
		else $error("normal write altered");
	a_preset_ones: assert property (
		wr_valid && xi_write && byte_preset[0] && !byte_reset[0] |=> wr_out_data[7:0] == 8'hFF)
		else $error("preset byte not ones");
	a_size_hold_high: assert property (
		gen_a && index_size_field[0] == 3'h3
		|=> {index_q[0][31:28], index_q[0][7:4]} == $past({index_q[0][31:28], index_q[0][7:4]}))
		else $error("protected index bits changed");
endmodule

// file: tb/iob_partner.sv
// model of the alu status and internal buses facing the block
module iob_partner (
	// clock and control
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ld,
	input wire logic [31:0] rnd,
	// buses by select code, their sizes, status
	output logic [3:0][31:0] bus,
	output logic [3:0][1:0] bsz,
	output logic [31:0] sta
);
	timeunit 1ns;
	timeprecision 1ps;
	// values move only on ld, so the bench can predict them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus <= '0;
			bsz <= '0;
			sta <= '0;
		end else if (ld) begin
			bus <= {rnd, ~rnd, {rnd[15:0], rnd[31:16]}, rnd ^ 32'h5A5A_A5A5};
			bsz <= rnd[7:0] ^ rnd[23:16];
			case (rnd[31:30])
				2'h0: sta <= rnd;
				2'h1: sta <= {{2{rnd[15:8]}}, {2{rnd[7:0]}}};
				default: sta <= {4{rnd[7:0]}};
			endcase
		end
	end
endmodule

// file: tb/index_offset_status_byte_enable_tb.sv
// self-checking bench for the index offset, status and byte enable block
module index_offset_status_byte_enable_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import iob_pkg::*;
	// ***************************************************************
	// signals
	// ***************************************************************
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, ld = 0, ga = 0, gb = 0, gc = 0, wv = 0, xi = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, wd = '0, rnd = '0;
	logic awready, wready, bvalid, arready, rvalid, wov;
	logic [1:0] bresp, rresp, rr, br;
	logic [31:0] rdata, wod, ia, ib, ic, sta, rv, d, c, e, m, sv, ea = '0;
	logic [3:0] wbe, x, s4;
	logic [3:0][31:0] bus;
	logic [3:0][1:0] bsz;
	integer seed = 32'h5612B7F3;
	int errors = 0, tests_run = 0, cyc = 0;
	iob_partner part_u (.aclk(aclk), .aresetn(aresetn), .ld(ld), .rnd(rnd),
		.bus(bus), .bsz(bsz), .sta(sta));
	iob_top dut_u (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.a_bus(bus[2]), .b_bus(bus[0]), .m_bus(bus[1]), .v_bus(bus[3]),
		.a_bus_size(bsz[2]), .b_bus_size(bsz[0]), .m_bus_size(bsz[1]), .v_bus_size(bsz[3]),
		.alu_range_status_reg(sta), .gen_a(ga), .gen_b(gb), .gen_c(gc),
		.wr_valid(wv), .xi_write(xi), .wr_data(wd), .wr_out_valid(wov),
		.wr_out_data(wod), .wr_out_byte_en(wbe), .index_a(ia), .index_b(ib), .index_c(ic)
	);
	initial forever #5 aclk = ~aclk;
	// ***************************************************************
	// tasks and expectations
	// ***************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// each channel released at its own handshake edge
	task wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge aclk);
		awaddr <= a;
		wdata <= dv;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		br = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	task load;
		@(posedge aclk);
		ld <= 1'b1;
		rnd <= $random(seed);
		@(posedge aclk);
		ld <= 1'b0;
	endtask
	task gen(input logic [2:0] g);
		@(posedge aclk);
		{gc, gb, ga} <= g;
		@(posedge aclk);
		{gc, gb, ga} <= 3'h0;
		@(negedge aclk);
	endtask
	task item(input logic xv, input logic [31:0] dv);
		@(posedge aclk);
		wv <= 1'b1;
		xi <= xv;
		wd <= dv;
		@(posedge aclk);
		wv <= 1'b0;
		@(negedge aclk);
		chk(32'(wov), 32'h1);
	endtask
	function automatic logic [31:0] offs(input logic [1:0] s);
		case (bsz[s])
			2'h0: return bus[s];
			2'h1: return {{2{bus[s][23:16]}}, {2{bus[s][7:0]}}};
			default: return {4{bus[s][7:0]}};
		endcase
	endfunction
	function automatic logic [3:0] st(input logic [2:0] n);
		return {sta[24+n], sta[16+n], sta[8+n], sta[n]};
	endfunction
	function automatic logic pf(input logic [1:0] md, input logic s);
		return md == 2'h3 || (md == 2'h1 && s) || (md == 2'h2 && !s);
	endfunction
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end
	// ***************************************************************
	// scenarios
	// ***************************************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(IOB_ADDR_SIZE);
		chk(rv, IOB_SIZE_RST);
		rd(8'h40);
		chk(32'(rr), 32'(IOB_RESP_SLVERR));
		wr(8'h40, 32'h1);
		chk(32'(br), 32'(IOB_RESP_SLVERR));
		// late passes narrow port a to four bits, upper bits must hold
		for (int i = 0; i < 8; i++) begin
			load();
			m = i < 4 ? '1 : 32'h0F0F_0F0F;
			wr(IOB_ADDR_SIZE, i < 4 ? 32'hF777 : 32'hF773);
			wr(IOB_ADDR_VECTOR, 32'h2200 | 32'(i % 4));
			gen(3'h3);
			ea = ea & ~m | offs(2'(i)) & m;
			chk(ia, ea);
			chk(ib, offs(2'(i)));
		end
		for (int k = 0; k < 24; k++) begin
			load();
			wr(IOB_ADDR_VECTOR, 32'((k / 8 == 1) << 6 | (k < 16) << 5 | k % 8 << 2));
			d = $random(seed);
			item(1'b0, d);
			chk(wod, d);
			chk(32'(wbe), 32'(k < 16 ? st(3'(k)) ^ {4{k / 8 == 1}} : 4'hF));
		end
		wr(IOB_ADDR_SIZE, IOB_SIZE_RST);
		wr(IOB_ADDR_VECTOR, 32'h0300_0CAC);
		load();
		gen(3'h1);
		// status only settles after the load edge; it stands until the next load
		sv = 32'(st(3'h3));
		load();
		rd(IOB_ADDR_C_FLAGS);
		chk(32'(rv[19:16]), sv);
		item(1'b0, 32'h0);
		chk(32'(wbe), sv);
		gen(3'h1);
		e = {7'h0, sv[3], 7'h0, sv[2], 7'h0, sv[1], 7'h0, sv[0]};
		chk(ia, e);
		gen(3'h4);
		chk(ic, e);
		for (int k = 0; k < 8; k++) begin
			load();
			wr(IOB_ADDR_VECTOR, 32'(k << 2));
			c = $random(seed);
			wr(IOB_ADDR_C_FLAGS, c);
			d = $random(seed);
			s4 = st(3'(k));
			item(k[0], d);
			e = d;
			for (int y = 0; y < 4; y++) begin
				if (k[0] && pf(c[8+2*y+:2], s4[y])) e[8*y+:8] = 8'h00;
				else if (k[0] && pf(c[2*y+:2], s4[y])) e[8*y+:8] = 8'hFF;
			end
			chk(wod, e);
		end
		load();
		x = 4'($random(seed));
		wr(IOB_ADDR_SIZE, 32'h0001_0777 | 32'(x) << 12);
		wr(IOB_ADDR_VECTOR, 32'h34);
		item(1'b0, 32'h0);
		chk(32'(wbe), 32'(x & st(3'h5)));
		wrap_up();
	end
endmodule
